/* hw/uart_irq_pkg.sv */
// shared constants and types of the eight-line interrupt scanner and summary block
package uart_irq_pkg;

   // ------------------------------------------------------------
   // structure
   // ------------------------------------------------------------
   localparam int          LINES          = 8;
   localparam int          SYNC_STAGES    = 2;

   // ------------------------------------------------------------
   // channel mode encodings
   // ------------------------------------------------------------
   localparam logic [1:0]  MODE_NORMAL    = 2'h0;
   localparam logic [1:0]  MODE_ECHO      = 2'h1;
   localparam logic [1:0]  MODE_LOCAL     = 2'h2;
   localparam logic [1:0]  MODE_REMOTE    = 2'h3;

   // ------------------------------------------------------------
   // field positions of the per-line command and mode-1 bytes and of the summary byte
   // ------------------------------------------------------------
   localparam int          MODE_HI_BIT    = 7;
   localparam int          MODE_LO_BIT    = 6;
   localparam int          RECEIVE_IRQ_ENABLE_BIT       = 5;
   localparam int          RECEIVER_ENABLE_BIT_BIT       = 2;
   localparam int          TRANSMIT_IRQ_ENABLE_BIT       = 1;
   localparam int          TRANSMITTER_ENABLE_BIT_BIT       = 0;
   localparam int          MODEM_CHANGE_IRQ_ENABLE_BIT       = 0;
   localparam int          SUM_IRQ_BIT    = 7;

   // ------------------------------------------------------------
   // low address codes on ADD[2:0]
   // ------------------------------------------------------------
   localparam logic [2:0]  CODE_MODE1     = 3'h0;
   localparam logic [2:0]  CODE_COMMAND   = 3'h2;
   localparam logic [2:0]  CODE_IRQ_SUM   = 3'h6;
   localparam logic [2:0]  CODE_CHG_SUM   = 3'h7;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 50;
   localparam int          CHANGE_GAP_NS  = 1000;
   localparam int          CHANGE_GAP_CYC = CHANGE_GAP_NS / CLK_PERIOD_NS;
   localparam logic [1:0]  ARM_CYCLES     = 2'h3;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] mode;
      logic       rx_irq_en;
      logic       rx_en;
      logic       tx_irq_en;
      logic       tx_en;
      logic       modem_change_irq_enable;
   } chan_ctrl_type;

   typedef struct packed {
      logic       direction;
      logic [2:0] line;
   } irq_report_type;

   localparam chan_ctrl_type CTRL_RESET   = '{mode: MODE_NORMAL, default: 1'b0};
   localparam logic [7:0]    CHG_RESET    = 8'h00;
   localparam logic [3:0]    SCAN_RESET   = 4'h0;

endpackage

/* hw/uart_irq_scanner.sv */
// eight-line test modes, summary registers and round-robin interrupt scanner
module uart_irq_scanner
   import uart_irq_pkg::*;
#(
   parameter logic [2:0] IRQ_SUM_CODE = CODE_IRQ_SUM,
   parameter logic [2:0] CHG_SUM_CODE = CODE_CHG_SUM
) (
   input  wire logic            CLK,
   input  wire logic            RESET_N,
   input  wire logic            CS_N,
   input  wire logic            DS_N,
   input  wire logic            WR_N,
   input  wire logic [5:0]      ADD,
   input  wire logic [7:0]      DL_IN,
   output      logic [7:0]      DL_OUT,
   output      logic            DL_OE,
   output      logic            IRQ_N,
   output      logic [2:0]      IRQ_LINE_NUMBER_OUT,
   output      logic            IRQ_DIRECTION_OUT,
   input  wire logic [7:0]      DATA_SET_READY_IN,
   input  wire logic [7:0]      CARRIER_DETECT_IN,
   input  wire logic [7:0]      RXD,
   output      logic [7:0]      TXD,
   input  wire logic [7:0]      CORE_RX_FULL,
   input  wire logic [7:0]      CORE_TX_HOLD_EMPTY,
   input  wire logic [7:0]      CORE_TX_SHIFT_EMPTY,
   input  wire logic [7:0]      CORE_TX_SERIAL,
   output      logic [7:0]      CORE_RX_SERIAL,
   output      logic [7:0]      RECEIVER_ENABLE_BIT,
   output      logic [7:0]      TRANSMITTER_ENABLE_BIT,
   output      logic [7:0]      RECEIVE_BUFFER_FULL_FLAG,
   output      logic [7:0]      TRANSMIT_HOLDING_EMPTY_FLAG,
   output      logic [7:0]      TRANSMITTER_IDLE_FLAG,
   output      logic            REPORT_VALID,
   input  wire logic            REPORT_READY,
   output      irq_report_type  REPORT_DATA
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // bus pins and line pins all cross in from outside the clock domain
   localparam int PIN_W = 3 + 6 + 8 + 8 + 8 + 8;

   wire  [PIN_W-1:0] pin_raw = {CS_N, DS_N, WR_N, ADD, DL_IN,
                                DATA_SET_READY_IN, CARRIER_DETECT_IN, RXD};
   logic [PIN_W-1:0] pin_s1_reg;
   logic [PIN_W-1:0] pin_s2_reg;
   logic             ds_n_prev_reg;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1_reg    <= {3'h7, {(PIN_W-3){1'b0}}};
         pin_s2_reg    <= {3'h7, {(PIN_W-3){1'b0}}};
         ds_n_prev_reg <= 1'b1;
      end else begin
         pin_s1_reg    <= pin_raw;
         pin_s2_reg    <= pin_s1_reg;
         ds_n_prev_reg <= pin_s2_reg[PIN_W-2];
      end
   end

   wire       cs_n_s = pin_s2_reg[PIN_W-1];
   wire       ds_n_s = pin_s2_reg[PIN_W-2];
   wire       wr_n_s = pin_s2_reg[PIN_W-3];
   wire [5:0] add_s  = pin_s2_reg[PIN_W-4 -: 6];
   wire [7:0] dl_s   = pin_s2_reg[31:24];
   wire [7:0] dsr_s  = pin_s2_reg[23:16];
   wire [7:0] dcd_s  = pin_s2_reg[15:8];
   wire [7:0] rxd_s  = pin_s2_reg[7:0];

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire       strobe     = !cs_n_s && !ds_n_s && ds_n_prev_reg;
   wire       wr_strobe  = strobe && !wr_n_s;
   wire [2:0] code       = add_s[2:0];
   wire [2:0] line_sel   = add_s[5:3];
   wire       sel_irq    = (code == IRQ_SUM_CODE);
   wire       sel_chg    = (code == CHG_SUM_CODE);
   wire       sel_cmd    = (code == CODE_COMMAND);
   wire       sel_mode1  = (code == CODE_MODE1);
   wire       mapped     = sel_irq || sel_chg || sel_cmd || sel_mode1;

   // ------------------------------------------------------------
   // per-line control, modes and flags
   // ------------------------------------------------------------
   chan_ctrl_type ctrl_reg [LINES];
   logic [7:0]    chg_reg;
   logic [7:0]    rx_full_m;
   logic [7:0]    tx_empty_m;
   logic [7:0]    tx_idle_m;
   logic [7:0]    rx_cond;
   logic [7:0]    tx_cond;
   logic [7:0]    txd_next;
   logic [7:0]    rx_serial_next;
   logic [7:0]    cmd_byte [LINES];
   logic [1:0]    arm_cnt_reg;
   logic [7:0]    dsr_prev_reg;
   logic [7:0]    dcd_prev_reg;
   wire           armed = (arm_cnt_reg == ARM_CYCLES);

   for (genvar i = 0; i < LINES; i++) begin : g_line
      wire [1:0] md      = ctrl_reg[i].mode;
      wire       tx_live = (md == MODE_NORMAL) || (md == MODE_LOCAL);
      wire       hit_cmd = wr_strobe && sel_cmd && (line_sel == 3'(i));
      wire       hit_mr1 = wr_strobe && sel_mode1 && (line_sel == 3'(i));
      wire [1:0] md_new  = dl_s[MODE_HI_BIT:MODE_LO_BIT];
      wire       md_rem  = hit_cmd ? (md_new == MODE_REMOTE) : (md == MODE_REMOTE);
      wire       chg_set = armed && ((dsr_s[i] ^ dsr_prev_reg[i]) ||
                                     (dcd_s[i] ^ dcd_prev_reg[i]));
      wire       chg_clr = wr_strobe && sel_chg && dl_s[i];

      // receiver and transmitter enable bits are forced low for as long as remote loopback stands
      always_ff @(posedge CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            ctrl_reg[i] <= CTRL_RESET;
         end else begin
            if (hit_cmd) begin
               ctrl_reg[i].mode      <= md_new;
               ctrl_reg[i].rx_irq_en <= dl_s[RECEIVE_IRQ_ENABLE_BIT];
               ctrl_reg[i].tx_irq_en <= dl_s[TRANSMIT_IRQ_ENABLE_BIT];
               ctrl_reg[i].rx_en     <= dl_s[RECEIVER_ENABLE_BIT_BIT];
               ctrl_reg[i].tx_en     <= dl_s[TRANSMITTER_ENABLE_BIT_BIT];
            end
            if (hit_mr1) begin
               ctrl_reg[i].modem_change_irq_enable <= dl_s[MODEM_CHANGE_IRQ_ENABLE_BIT];
            end
            if (md_rem) begin
               ctrl_reg[i].rx_en <= 1'b0;
               ctrl_reg[i].tx_en <= 1'b0;
            end
         end
      end

      // set beats a simultaneous write-one clear
      always_ff @(posedge CLK or negedge RESET_N) begin
         if (!RESET_N) begin
            chg_reg[i] <= CHG_RESET[i];
         end else begin
            chg_reg[i] <= chg_set || (chg_reg[i] && !chg_clr);
         end
      end

      assign cmd_byte[i] = {md, ctrl_reg[i].rx_irq_en, 2'b00, ctrl_reg[i].rx_en,
                            ctrl_reg[i].tx_irq_en, ctrl_reg[i].tx_en};
      // echo and remote silence the transmitter flags; only remote silences the receiver flag
      assign rx_full_m[i]  = CORE_RX_FULL[i] && (md != MODE_REMOTE);
      assign tx_empty_m[i] = CORE_TX_HOLD_EMPTY[i] && tx_live;
      assign tx_idle_m[i]  = tx_empty_m[i] && CORE_TX_SHIFT_EMPTY[i];
      assign rx_cond[i]    = ctrl_reg[i].rx_irq_en &&
                             (rx_full_m[i] || (chg_reg[i] && ctrl_reg[i].modem_change_irq_enable));
      assign tx_cond[i]    = tx_empty_m[i] && ctrl_reg[i].tx_irq_en;
      // rate selection stays with the core; loopback only re-routes the bit stream
      assign rx_serial_next[i] = (md == MODE_LOCAL) ? CORE_TX_SERIAL[i] : rxd_s[i];
      assign txd_next[i] = (md == MODE_NORMAL) ? CORE_TX_SERIAL[i] :
                           (md == MODE_LOCAL)  ? 1'b1 :
                                                 rxd_s[i];

      assign RECEIVER_ENABLE_BIT[i]    = ctrl_reg[i].rx_en;
      assign TRANSMITTER_ENABLE_BIT[i] = ctrl_reg[i].tx_en && tx_live;

      chk_local_txd_high: assert property (@(posedge CLK) disable iff (!RESET_N)
         (md == MODE_LOCAL) [*2] |=> TXD[i]) else $error("txd not high in loopback");
      chk_echo_tx_quiet: assert property (@(posedge CLK) disable iff (!RESET_N)
         (md == MODE_ECHO) |-> !tx_cond[i] && !TRANSMITTER_ENABLE_BIT[i])
         else $error("transmitter active in echo");
      chk_remote_en_low: assert property (@(posedge CLK) disable iff (!RESET_N)
         (md == MODE_REMOTE) |-> !ctrl_reg[i].rx_en && !ctrl_reg[i].tx_en)
         else $error("enable bit set in remote loopback");
      chk_change_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
         chg_set |=> chg_reg[i]) else $error("line change not flagged");
      chk_w1c_clears: assert property (@(posedge CLK) disable iff (!RESET_N)
         chg_clr && !chg_set |=> !chg_reg[i]) else $error("write one did not clear");
      chk_echo_copy: assert property (@(posedge CLK) disable iff (!RESET_N)
         (md == MODE_ECHO) |=> TXD[i] == $past(rxd_s[i]))
         else $error("echo input not copied to serial output");
      chk_local_feed: assert property (@(posedge CLK) disable iff (!RESET_N)
         (md == MODE_LOCAL) |=> CORE_RX_SERIAL[i] == $past(CORE_TX_SERIAL[i]))
         else $error("receiver not fed from transmitter in loopback");
      chk_remote_flags_low: assert property (@(posedge CLK) disable iff (!RESET_N)
         (md == MODE_REMOTE) |=> !RECEIVE_BUFFER_FULL_FLAG[i] && !TRANSMITTER_IDLE_FLAG[i])
         else $error("flag raised in remote loopback");
      chk_idle_needs_empty: assert property (@(posedge CLK) disable iff (!RESET_N)
         TRANSMITTER_IDLE_FLAG[i] |-> TRANSMIT_HOLDING_EMPTY_FLAG[i])
         else $error("idle shown with holding register full");
      chk_rx_source: assert property (@(posedge CLK) disable iff (!RESET_N)
         rx_cond[i] |-> ctrl_reg[i].rx_irq_en && (CORE_RX_FULL[i] || (chg_reg[i] && ctrl_reg[i].modem_change_irq_enable)))
         else $error("receive source without its condition");
   end

   // ------------------------------------------------------------
   // change detector arming
   // ------------------------------------------------------------
   // no comparison until the sync chain holds real pin levels
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         arm_cnt_reg  <= 2'h0;
         dsr_prev_reg <= 8'h00;
         dcd_prev_reg <= 8'h00;
      end else begin
         if (!armed) begin
            arm_cnt_reg <= 2'(arm_cnt_reg + 2'h1);
         end
         dsr_prev_reg <= dsr_s;
         dcd_prev_reg <= dcd_s;
      end
   end

   // ------------------------------------------------------------
   // line-side outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TXD                         <= 8'hFF;
         CORE_RX_SERIAL              <= 8'hFF;
         RECEIVE_BUFFER_FULL_FLAG    <= 8'h00;
         TRANSMIT_HOLDING_EMPTY_FLAG <= 8'h00;
         TRANSMITTER_IDLE_FLAG       <= 8'h00;
      end else begin
         TXD                         <= txd_next;
         CORE_RX_SERIAL              <= rx_serial_next;
         RECEIVE_BUFFER_FULL_FLAG    <= rx_full_m;
         TRANSMIT_HOLDING_EMPTY_FLAG <= tx_empty_m;
         TRANSMITTER_IDLE_FLAG       <= tx_idle_m;
      end
   end

   // ------------------------------------------------------------
   // interrupt scanner
   // ------------------------------------------------------------
   logic [3:0] pos_reg;
   logic       stopped_reg;
   logic       fifo_in_ready;
   wire        hit        = pos_reg[3] ? tx_cond[pos_reg[2:0]] : rx_cond[pos_reg[2:0]];
   wire        push       = !stopped_reg && hit && fifo_in_ready;
   wire        released   = stopped_reg && !hit;
   // a full report buffer stalls the count on the pending source
   wire        stall      = !stopped_reg && hit && !fifo_in_ready;
   wire [3:0]  pos_next   = released ? (pos_reg[3] ? 4'h0 : 4'(pos_reg + 4'h1)) :
                            (stopped_reg || hit || stall) ? pos_reg :
                            4'(pos_reg + 4'h1);
   // line number sits above the direction bit, unlike the counter's own order
   wire [7:0]  irq_summary = {stopped_reg, 3'b000, pos_reg[2:0], pos_reg[3]};

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pos_reg     <= SCAN_RESET;
         stopped_reg <= 1'b0;
      end else begin
         pos_reg     <= pos_next;
         stopped_reg <= push || (stopped_reg && hit);
      end
   end

   assign IRQ_N               = !stopped_reg;
   assign IRQ_LINE_NUMBER_OUT = pos_reg[2:0];
   assign IRQ_DIRECTION_OUT   = pos_reg[3];

   uart_report_fifo #(
      .WIDTH     ($bits(irq_report_type))
   ) u_report (
      .CLK       (CLK),
      .RESET_N   (RESET_N),
      .in_valid  (!stopped_reg && hit),
      .in_ready  (fifo_in_ready),
      .in_data   ({pos_reg[3], pos_reg[2:0]}),
      .out_valid (REPORT_VALID),
      .out_ready (REPORT_READY),
      .out_data  (REPORT_DATA)
   );

   // ------------------------------------------------------------
   // register read path
   // ------------------------------------------------------------
   wire [7:0] rd_sel = sel_irq   ? irq_summary :
                       sel_chg   ? chg_reg :
                       sel_cmd   ? cmd_byte[line_sel] :
                       sel_mode1 ? {7'h00, ctrl_reg[line_sel].modem_change_irq_enable} : 8'h00;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DL_OUT <= 8'h00;
         DL_OE  <= 1'b0;
      end else begin
         if (strobe && wr_n_s) begin
            DL_OUT <= rd_sel;
         end
         DL_OE <= !cs_n_s && !ds_n_s && wr_n_s && mapped;
      end
   end

   // ------------------------------------------------------------
   // scanner and read-path checks
   // ------------------------------------------------------------
   chk_irq_summary_top: assert property (@(posedge CLK) disable iff (!RESET_N)
      !IRQ_N |-> irq_summary[SUM_IRQ_BIT] && (irq_summary[6:4] == 3'b000))
      else $error("summary top bit disagrees with request");
   chk_summary_mirror: assert property (@(posedge CLK) disable iff (!RESET_N)
      irq_summary[3:0] == {IRQ_LINE_NUMBER_OUT, IRQ_DIRECTION_OUT})
      else $error("summary low bits not mirroring outputs");
   chk_scan_step: assert property (@(posedge CLK) disable iff (!RESET_N)
      !stopped_reg && !hit |=> pos_reg == 4'($past(pos_reg) + 4'h1))
      else $error("scanner did not advance");
   chk_stop_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
      push ##1 hit |=> !IRQ_N && $stable(pos_reg))
      else $error("scanner left a pending source");
   chk_tx_restart: assert property (@(posedge CLK) disable iff (!RESET_N)
      released && pos_reg[3] |=> IRQ_N && (pos_reg == 4'h0))
      else $error("transmit stop did not restart at zero");
   chk_rx_resume: assert property (@(posedge CLK) disable iff (!RESET_N)
      released && !pos_reg[3] |=> IRQ_N && (pos_reg == 4'($past(pos_reg) + 4'h1)))
      else $error("receive stop did not resume");
   chk_req_line: assert property (@(posedge CLK) disable iff (!RESET_N)
      push |=> !IRQ_N && (IRQ_LINE_NUMBER_OUT == $past(pos_reg[2:0]))
               && (IRQ_DIRECTION_OUT == $past(pos_reg[3])))
      else $error("line number or direction wrong on stop");
   chk_oe_read_only: assert property (@(posedge CLK) disable iff (!RESET_N)
      DL_OE |-> $past(wr_n_s) && $past(mapped))
      else $error("data bus driven outside a mapped read");

endmodule

/* hw/uart_report_fifo.sv */
// two-entry buffer with valid and ready on both sides
module uart_report_fifo
   import uart_irq_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input  wire logic             CLK,
   input  wire logic             RESET_N,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0] mem_reg [2];
   logic             wr_ptr_reg;
   logic             rd_ptr_reg;
   logic [1:0]       count_reg;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data  = mem_reg[rd_ptr_reg];

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
      end
   end

endmodule

/* tb/host_model.sv */
// host processor model driving the register bus pins
module host_model (
   input  wire logic       CLK,
   output      logic       CS_N,
   output      logic       DS_N,
   output      logic       WR_N,
   output      logic [5:0] ADD,
   output      logic [7:0] DL_IN,
   input  wire logic [7:0] DL_OUT,
   input  wire logic       DL_OE
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       oe_seen;

   initial begin
      CS_N  = 1'b1;
      DS_N  = 1'b1;
      WR_N  = 1'b1;
      ADD   = 6'h00;
      DL_IN = 8'h00;
   end

   // ------------------------------------------------------------
   // one strobe per access; strobe high long enough to re-arm
   // ------------------------------------------------------------
   task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge CLK);
      #5;
      CS_N  = 1'b0;
      DS_N  = 1'b0;
      WR_N  = ~wr;
      ADD   = a;
      DL_IN = d;
      repeat (6) @(posedge CLK);
      #1;
      q = DL_OUT;
      oe_seen = DL_OE;
      #4;
      DS_N  = 1'b1;
      CS_N  = 1'b1;
      DL_IN = ~d;
      repeat (4) @(posedge CLK);
      #5;
   endtask

   // read, keep, write straight back so only seen bits clear
   task automatic ack_changes(input logic [2:0] code, output logic [7:0] seen);
      logic [7:0] dummy;
      access(1'b0, {3'h0, code}, 8'h00, seen);
      access(1'b1, {3'h0, code}, seen, dummy);
   endtask
endmodule

/* tb/test_uart_irq_scanner.sv */
// self-checking bench of the interrupt scanner and summary block
module test_uart_irq_scanner
   import uart_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic CLK = 1'b0, RESET_N = 1'b0, CS_N, DS_N, WR_N, IRQ_N, IRQ_DIRECTION_OUT, REPORT_VALID;
   logic REPORT_READY = 1'b0;
   logic [5:0] ADD;
   logic [7:0] DL_IN, DL_OUT, TXD, CORE_RX_SERIAL, ren, ten, rff, thf, tif, q;
   logic [7:0] DSR = 8'h00, DCD = 8'h00, RXD = 8'hFF, RXF = 8'h00, THE = 8'h00;
   logic [7:0] TSE = 8'hFF, TSER = 8'hFF;
   logic [2:0] IRQ_LINE_NUMBER_OUT;
   logic DL_OE;
   irq_report_type REPORT_DATA;
   int fail_count = 0, n_checks = 0;

   always #25 CLK = ~CLK;

   uart_irq_scanner i_uart_irq_scanner (.CLK(CLK), .RESET_N(RESET_N), .CS_N(CS_N),
      .DS_N(DS_N), .WR_N(WR_N), .ADD(ADD), .DL_IN(DL_IN), .DL_OUT(DL_OUT), .DL_OE(DL_OE),
      .IRQ_N(IRQ_N), .IRQ_LINE_NUMBER_OUT(IRQ_LINE_NUMBER_OUT),
      .IRQ_DIRECTION_OUT(IRQ_DIRECTION_OUT), .DATA_SET_READY_IN(DSR),
      .CARRIER_DETECT_IN(DCD), .RXD(RXD), .TXD(TXD), .CORE_RX_FULL(RXF),
      .CORE_TX_HOLD_EMPTY(THE), .CORE_TX_SHIFT_EMPTY(TSE), .CORE_TX_SERIAL(TSER),
      .CORE_RX_SERIAL(CORE_RX_SERIAL), .RECEIVER_ENABLE_BIT(ren),
      .TRANSMITTER_ENABLE_BIT(ten), .RECEIVE_BUFFER_FULL_FLAG(rff),
      .TRANSMIT_HOLDING_EMPTY_FLAG(thf), .TRANSMITTER_IDLE_FLAG(tif),
      .REPORT_VALID(REPORT_VALID), .REPORT_READY(REPORT_READY), .REPORT_DATA(REPORT_DATA));

   host_model i_host_model (.CLK(CLK), .CS_N(CS_N), .DS_N(DS_N), .WR_N(WR_N), .ADD(ADD),
      .DL_IN(DL_IN), .DL_OUT(DL_OUT), .DL_OE(DL_OE));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // request sensed as a level, bounded wait
   task automatic wait_irq(input logic lvl);
      int n = 0;
      while (IRQ_N !== lvl && n < 60) begin
         @(posedge CLK);
         #5;
         n++;
      end
      if (IRQ_N !== lvl) begin
         fail_count++;
         $display("MISMATCH %0t request wait ran out", $time);
         close_out();
      end
   endtask

   task automatic cmd(input logic [2:0] line, input logic [7:0] v);
      i_host_model.access(1'b1, {line, CODE_COMMAND}, v, q);
   endtask

   task automatic settle();
      repeat (6) @(posedge CLK);
      #5;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic sc_receive_stop();
      RXF[3] = 1'b1;
      cmd(3'h3, 8'h24); // rx irq enable and rx enable
      wait_irq(1'b0);
      check({5'h0, IRQ_LINE_NUMBER_OUT}, 8'h03);
      check({7'h0, IRQ_DIRECTION_OUT}, 8'h00);
      i_host_model.access(1'b0, {3'h5, CODE_IRQ_SUM}, 8'h00, q);
      check(q, 8'h86);
      check({6'h0, i_host_model.oe_seen, DL_OE}, 8'h02);
      check({3'h0, REPORT_VALID, REPORT_DATA}, 8'h13);
      REPORT_READY = 1'b1;
      RXF[3] = 1'b0;
      wait_irq(1'b1);
   endtask

   task automatic sc_transmit_stop();
      THE[2] = 1'b1;
      cmd(3'h2, 8'h03); // tx irq enable and tx enable
      wait_irq(1'b0);
      i_host_model.access(1'b0, {3'h0, CODE_IRQ_SUM}, 8'h00, q);
      check(q, 8'h85);
      check({7'h0, tif[2]}, 8'h01);
      TSE[2] = 1'b0;
      settle();
      check({7'h0, tif[2]}, 8'h00);
      check({7'h0, thf[2]}, 8'h01);
   endtask

   task automatic sc_modes();
      cmd(3'h2, {MODE_ECHO, 6'h03});
      wait_irq(1'b1);
      check({6'h0, ten[2], thf[2]}, 8'h00);
      RXD[2] = 1'b0;
      settle();
      check({7'h0, TXD[2]}, 8'h00);
      cmd(3'h2, {MODE_LOCAL, 6'h07});
      TSER[2] = 1'b0;
      settle();
      check({6'h0, TXD[2], CORE_RX_SERIAL[2]}, 8'h02);
      cmd(3'h2, {MODE_REMOTE, 6'h07});
      RXD[2] = 1'b1;
      settle();
      check({7'h0, TXD[2]}, 8'h01);
      RXD[2] = 1'b0;
      RXF[2] = 1'b1;
      settle();
      check({4'h0, rff[2], TXD[2], ren[2], ten[2]}, 8'h00);
   endtask

   task automatic sc_change_flags();
      DSR[4] = 1'b1;
      repeat (25) @(posedge CLK);
      #5;
      DCD[6] = 1'b1;
      repeat (25) @(posedge CLK);
      #5;
      i_host_model.ack_changes(CODE_CHG_SUM, q);
      check(q, 8'h50);
      i_host_model.access(1'b0, {3'h7, CODE_CHG_SUM}, 8'h00, q);
      check(q, 8'h00);
   endtask

   initial begin
      repeat (6) @(posedge CLK);
      #5;
      check({IRQ_N, 7'h0}, 8'h80);
      check(TXD, 8'hFF);
      RESET_N = 1'b1;
      repeat (4) @(posedge CLK);
      #5;
      sc_receive_stop();
      sc_transmit_stop();
      sc_modes();
      sc_change_flags();
      close_out();
   end
endmodule
